// [hdl/ihbs_bus_if.sv]
// Bus carrier joining host end and device end; resolves shared wires.
// Assumes pull-ups on data and open-drain lines, pull-downs on interrupts.
`timescale 1ns/1ps
interface ihbs_bus_if;
    import ihbs_pkg::*;
    ihbs_addr_t sa;
    logic aen;
    logic bale;
    ihbs_stb_t stb;
    ihbs_data_t hostSd;
    logic hostSdOe;
    ihbs_data_t devSd;
    logic [1:0] devSdOe;
    logic cs16Oe;
    logic rdyOe;
    logic [4:0] irqOut;
    logic [4:0] irqOe;
    ihbs_data_t sd;
    logic iocs16N;
    logic iochrdy;
    logic [4:0] irq;

    // ------------------------------------------------------------
    // Wire resolution
    // ------------------------------------------------------------
    assign sd[7:0] = hostSdOe ? hostSd[7:0] :
                     devSdOe[0] ? devSd[7:0] : 8'hFF;
    assign sd[15:8] = hostSdOe ? hostSd[15:8] :
                      devSdOe[1] ? devSd[15:8] : 8'hFF;
    assign iocs16N = ~cs16Oe;
    assign iochrdy = ~rdyOe;
    assign irq = irqOut & irqOe;

    modport host (
        output sa, aen, bale, stb, hostSd, hostSdOe,
        input sd, iocs16N, iochrdy, irq
    );
    modport dev (
        input sa, aen, bale, stb, sd,
        output devSd, devSdOe, cs16Oe, rdyOe, irqOut, irqOe
    );
endinterface : ihbs_bus_if

// [hdl/ihbs_cfg.svh]
// Constants of the ISA host bus slave front end: timing and encodings.
// Assumes a 250 MHz clock shared by both ends of the bus.
// Notes on behaviour
// - High address enable marks DMA; ignore IO.
// - Latch address on address-latch-enable falling edge.
// - Short memory strobes only below first megabyte.
// - Full-range memory strobes anywhere in space.
// - Full-range read pin decides 8/16-bit system.
// - IO transfers only while IO strobe asserted.
// - Pull 16-bit IO select low on hits.
// - Ready low stretches cycle; host waits.
// - High-enable low moves data on upper lanes.
// - At most one of five interrupt pins driven.
`ifndef IHBS_CFG_SVH
`define IHBS_CFG_SVH

`define IHBS_CLK_NS 4
`define IHBS_T_ADDR_NS 16
`define IHBS_T_STROBE_NS 64
`define IHBS_T_REC_NS 16
`define IHBS_T_ADDR_CYC ((`IHBS_T_ADDR_NS + `IHBS_CLK_NS - 1) / `IHBS_CLK_NS)
`define IHBS_T_STB_CYC ((`IHBS_T_STROBE_NS + `IHBS_CLK_NS - 1) / `IHBS_CLK_NS)
`define IHBS_T_REC_CYC ((`IHBS_T_REC_NS + `IHBS_CLK_NS - 1) / `IHBS_CLK_NS)
`define IHBS_IRQ_NUM 5
`define IHBS_IRQ_NONE 3'h7
`define IHBS_LOW_MB_TOP 4'h0
`define IHBS_STB_IDLE 7'h7F

`endif

// [hdl/ihbs_dev.sv]
// Device end: decodes host cycles, stretches them, drives interrupts.
// Assumes all bus pins asynchronous to clock; user side is synchronous.
`timescale 1ns/1ps
`include "ihbs_cfg.svh"
module ihbs_dev (
    input wire logic clock,                  // 250 MHz clock
    input wire logic rstn,                   // Async reset, active low
    ihbs_bus_if.dev bus,                     // ISA pins
    input wire logic [11:0] ioBase,          // IO window, address [15:4]
    input wire logic [9:0] memBase,          // Memory window, addr [23:14]
    input wire logic [2:0] cfgIrqSel,        // Interrupt pin choice
    input wire logic cfgLoad,                // Load interrupt choice
    input wire logic intReq,                 // Interrupt request level
    output logic reqValid,                   // Access request pulse
    output logic reqWrite,                   // Request is a write
    output logic reqMem,                     // Request targets memory
    output logic reqWide,                    // Request is 16 bits
    output ihbs_pkg::ihbs_addr_t reqAddr,    // Latched address
    output ihbs_pkg::ihbs_data_t reqWdata,   // Write data
    input wire logic ackValid,               // Access done pulse
    input wire ihbs_pkg::ihbs_data_t ackData, // Read data
    output logic sys16                       // 16-bit system seen
);
    import ihbs_pkg::*;

    // ------------------------------------------------------------
    // Pin synchronisers
    // ------------------------------------------------------------
    ihbs_stb_t stbS1_q;
    ihbs_stb_t stbS2_q;
    logic [1:0] ctlS1_q;
    logic [1:0] ctlS2_q;
    ihbs_addr_t saS1_q;
    ihbs_addr_t saS2_q;
    ihbs_data_t sdS1_q;
    ihbs_data_t sdS2_q;

    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            stbS1_q <= `IHBS_STB_IDLE;
            stbS2_q <= `IHBS_STB_IDLE;
            ctlS1_q <= 2'h0;
            ctlS2_q <= 2'h0;
            saS1_q <= 24'h000000;
            saS2_q <= 24'h000000;
            sdS1_q <= 16'h0000;
            sdS2_q <= 16'h0000;
        end else begin
            stbS1_q <= bus.stb;
            stbS2_q <= stbS1_q;
            ctlS1_q <= {bus.aen, bus.bale};
            ctlS2_q <= ctlS1_q;
            saS1_q <= bus.sa;
            saS2_q <= saS1_q;
            sdS1_q <= bus.sd;
            sdS2_q <= sdS1_q;
        end
    end

    // ------------------------------------------------------------
    // Address latch and decode
    // ------------------------------------------------------------
    logic aenS;
    logic baleS;
    logic baleOld_q;
    ihbs_addr_t latAddr_q;
    ihbs_addr_t latAddr_d;
    logic ioSel_q;
    logic ioSel_d;
    logic memSel_q;
    logic memSel_d;
    logic [1:0] sysChk_q;
    logic [1:0] sysChk_d;
    logic sys16_q;
    logic sys16_d;

    assign aenS = ctlS2_q[1];
    assign baleS = ctlS2_q[0];

    function automatic logic ioHit(ihbs_addr_t a, logic [11:0] base);
        ioHit = (a[15:4] == base);
    endfunction : ioHit

    function automatic logic memHit(ihbs_addr_t a, logic [9:0] base);
        memHit = (a[23:14] == base);
    endfunction : memHit

    always_comb begin
        latAddr_d = latAddr_q;
        ioSel_d = ioSel_q;
        memSel_d = memSel_q;
        // Wait until synchroniser holds the pin
        sysChk_d = (sysChk_q == 2'h3) ? sysChk_q : sysChk_q + 2'h1;
        sys16_d = sys16_q;
        if (baleOld_q && !baleS) begin
            latAddr_d = saS2_q;
            ioSel_d = !aenS && ioHit(saS2_q, ioBase);
            memSel_d = memHit(saS2_q, memBase);
        end else if (baleS && !baleOld_q) begin
            ioSel_d = 1'b0;
            memSel_d = 1'b0;
        end else if (aenS) begin
            ioSel_d = 1'b0;
        end
        // connected full-range read pin idles high
        if (sysChk_q == 2'h2) begin
            sys16_d = stbS2_q.memrN;
        end
    end

    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            baleOld_q <= 1'b0;
            latAddr_q <= 24'h000000;
            ioSel_q <= 1'b0;
            memSel_q <= 1'b0;
            sysChk_q <= 2'h0;
            sys16_q <= 1'b0;
        end else begin
            baleOld_q <= baleS;
            latAddr_q <= latAddr_d;
            ioSel_q <= ioSel_d;
            memSel_q <= memSel_d;
            sysChk_q <= sysChk_d;
            sys16_q <= sys16_d;
        end
    end

    // ------------------------------------------------------------
    // Cycle engine
    // ------------------------------------------------------------
    logic lowMb;
    logic rdStb;
    logic wrStb;
    logic active;
    logic wide;
    ihbs_dst_t st_q;
    ihbs_dst_t st_d;
    logic reqValid_q;
    logic reqValid_d;
    logic reqWrite_q;
    logic reqWrite_d;
    logic reqMem_q;
    logic reqMem_d;
    logic reqWide_q;
    logic reqWide_d;
    ihbs_data_t reqWdata_q;
    ihbs_data_t reqWdata_d;
    ihbs_data_t sdOut_q;
    ihbs_data_t sdOut_d;
    logic [1:0] sdOe_q;
    logic [1:0] sdOe_d;
    logic rdyOe_q;
    logic rdyOe_d;
    logic cs16Oe_q;
    logic cs16Oe_d;

    // short strobes count only in first megabyte
    assign lowMb = (latAddr_q[23:20] == `IHBS_LOW_MB_TOP);
    // full-range strobes anywhere; IO strobes by type
    assign rdStb = (ioSel_q && !stbS2_q.iorN) || (memSel_q &&
                   (!stbS2_q.memrN || (lowMb && !stbS2_q.smemrN)));
    assign wrStb = (ioSel_q && !stbS2_q.iowN) || (memSel_q &&
                   (!stbS2_q.memwN || (lowMb && !stbS2_q.smemwN)));
    assign active = rdStb || wrStb;
    // upper lanes only in 16-bit system with high enable
    assign wide = sys16_q && !stbS2_q.sbheN;

    always_comb begin
        st_d = st_q;
        reqValid_d = 1'b0;
        reqWrite_d = reqWrite_q;
        reqMem_d = reqMem_q;
        reqWide_d = reqWide_q;
        reqWdata_d = reqWdata_q;
        sdOut_d = sdOut_q;
        sdOe_d = sdOe_q;
        rdyOe_d = rdyOe_q;
        // 16-bit select for own IO window
        cs16Oe_d = sys16_q && ioSel_q;
        unique case (st_q)
            IHBS_D_IDLE: begin
                sdOe_d = 2'b00;
                if (active) begin
                    reqValid_d = 1'b1;
                    reqWrite_d = wrStb;
                    reqMem_d = !(ioSel_q && (!stbS2_q.iorN ||
                                             !stbS2_q.iowN));
                    reqWide_d = wide;
                    reqWdata_d = sdS2_q;
                    rdyOe_d = 1'b1;
                    st_d = IHBS_D_WAIT;
                end
            end
            IHBS_D_WAIT: begin
                if (!active) begin
                    rdyOe_d = 1'b0;
                    st_d = IHBS_D_IDLE;
                end else if (ackValid) begin
                    rdyOe_d = 1'b0;
                    sdOut_d = ackData;
                    sdOe_d = reqWrite_q ? 2'b00 : {reqWide_q, 1'b1};
                    st_d = IHBS_D_HOLD;
                end
            end
            IHBS_D_HOLD: begin
                // drive data only while strobe holds
                if (!active) begin
                    sdOe_d = 2'b00;
                    st_d = IHBS_D_IDLE;
                end
            end
        endcase
    end

    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            st_q <= IHBS_D_IDLE;
            reqValid_q <= 1'b0;
            reqWrite_q <= 1'b0;
            reqMem_q <= 1'b0;
            reqWide_q <= 1'b0;
            reqWdata_q <= 16'h0000;
            sdOut_q <= 16'h0000;
            sdOe_q <= 2'h0;
            rdyOe_q <= 1'b0;
            cs16Oe_q <= 1'b0;
        end else begin
            st_q <= st_d;
            reqValid_q <= reqValid_d;
            reqWrite_q <= reqWrite_d;
            reqMem_q <= reqMem_d;
            reqWide_q <= reqWide_d;
            reqWdata_q <= reqWdata_d;
            sdOut_q <= sdOut_d;
            sdOe_q <= sdOe_d;
            rdyOe_q <= rdyOe_d;
            cs16Oe_q <= cs16Oe_d;
        end
    end

    // ------------------------------------------------------------
    // Interrupt pin selection
    // ------------------------------------------------------------
    logic [2:0] irqSel_q;
    logic [2:0] irqSel_d;
    logic [4:0] irqOut_q;
    logic [4:0] irqOut_d;
    logic [4:0] irqOe_q;
    logic [4:0] irqOe_d;

    always_comb begin
        irqSel_d = cfgLoad ? cfgIrqSel : irqSel_q;
        // at most one selected pin is driven; none for selections 5 to 7
        for (int i = 0; i < `IHBS_IRQ_NUM; i++) begin
            irqOe_d[i] = (irqSel_q == 3'(i));
            irqOut_d[i] = (irqSel_q == 3'(i)) && intReq;
        end
    end

    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            irqSel_q <= `IHBS_IRQ_NONE;
            irqOut_q <= 5'h00;
            irqOe_q <= 5'h00;
        end else begin
            irqSel_q <= irqSel_d;
            irqOut_q <= irqOut_d;
            irqOe_q <= irqOe_d;
        end
    end

    assign bus.devSd = sdOut_q;
    assign bus.devSdOe = sdOe_q;
    assign bus.cs16Oe = cs16Oe_q;
    assign bus.rdyOe = rdyOe_q;
    assign bus.irqOut = irqOut_q;
    assign bus.irqOe = irqOe_q;
    assign reqValid = reqValid_q;
    assign reqWrite = reqWrite_q;
    assign reqMem = reqMem_q;
    assign reqWide = reqWide_q;
    assign reqAddr = latAddr_q;
    assign reqWdata = reqWdata_q;
    assign sys16 = sys16_q;
endmodule : ihbs_dev

// [hdl/ihbs_host.sv]
// Host end: runs ISA memory and IO cycles on user command.
// Assumes device pins arrive asynchronous to clock.
`timescale 1ns/1ps
`include "ihbs_cfg.svh"
module ihbs_host (
    input wire logic clock,                  // 250 MHz clock
    input wire logic rstn,                   // Async reset, active low
    ihbs_bus_if.host bus,                    // ISA pins
    input wire logic cmdValid,               // Command offered
    input wire ihbs_pkg::ihbs_kind_t cmdKind, // Cycle kind
    input wire logic cmdDma,                 // Run as DMA cycle
    input wire logic cmdWide,                // 16-bit transfer
    input wire ihbs_pkg::ihbs_addr_t cmdAddr, // Cycle address
    input wire ihbs_pkg::ihbs_data_t cmdData, // Write data
    output logic cmdReady,                   // Command accepted when high
    output logic rspValid,                   // Cycle finished pulse
    output ihbs_pkg::ihbs_data_t rspData,    // Read data
    output logic rspIo16,                    // 16-bit select seen
    output logic [4:0] irqLevel              // Synchronised interrupts
);
    import ihbs_pkg::*;

    // ------------------------------------------------------------
    // Pin synchronisers
    // ------------------------------------------------------------
    logic [6:0] pinS1_q;
    logic [6:0] pinS2_q;
    ihbs_data_t sdS1_q;
    ihbs_data_t sdS2_q;

    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            pinS1_q <= 7'h03;
            pinS2_q <= 7'h03;
            sdS1_q <= 16'h0000;
            sdS2_q <= 16'h0000;
        end else begin
            pinS1_q <= {bus.irq, bus.iocs16N, bus.iochrdy};
            pinS2_q <= pinS1_q;
            sdS1_q <= bus.sd;
            sdS2_q <= sdS1_q;
        end
    end

    // ------------------------------------------------------------
    // Cycle sequencer
    // ------------------------------------------------------------
    function automatic ihbs_stb_t stbFor(ihbs_kind_t k, ihbs_addr_t a,
                                         logic w);
        logic low;
        low = (a[23:20] == `IHBS_LOW_MB_TOP);
        stbFor = `IHBS_STB_IDLE;
        stbFor.sbheN = !w;
        unique case (k)
            IHBS_IO_RD: stbFor.iorN = 1'b0;
            IHBS_IO_WR: stbFor.iowN = 1'b0;
            // short strobes only below first megabyte
            IHBS_MEM_RD: begin
                stbFor.memrN = 1'b0;
                stbFor.smemrN = !low;
            end
            IHBS_MEM_WR: begin
                stbFor.memwN = 1'b0;
                stbFor.smemwN = !low;
            end
        endcase
    endfunction : stbFor

    ihbs_hst_t st_q;
    ihbs_hst_t st_d;
    logic [7:0] cnt_q;
    logic [7:0] cnt_d;
    ihbs_kind_t kind_q;
    ihbs_kind_t kind_d;
    logic wide_q;
    logic wide_d;
    ihbs_addr_t sa_q;
    ihbs_addr_t sa_d;
    logic aen_q;
    logic aen_d;
    logic bale_q;
    logic bale_d;
    ihbs_stb_t stb_q;
    ihbs_stb_t stb_d;
    ihbs_data_t sdOut_q;
    ihbs_data_t sdOut_d;
    logic sdOe_q;
    logic sdOe_d;
    logic cmdReady_q;
    logic cmdReady_d;
    logic rspValid_q;
    logic rspValid_d;
    ihbs_data_t rspData_q;
    ihbs_data_t rspData_d;
    logic rspIo16_q;
    logic rspIo16_d;

    always_comb begin
        st_d = st_q;
        cnt_d = cnt_q;
        kind_d = kind_q;
        wide_d = wide_q;
        sa_d = sa_q;
        aen_d = aen_q;
        bale_d = bale_q;
        stb_d = stb_q;
        sdOut_d = sdOut_q;
        sdOe_d = sdOe_q;
        cmdReady_d = cmdReady_q;
        rspValid_d = 1'b0;
        rspData_d = rspData_q;
        rspIo16_d = rspIo16_q;
        unique case (st_q)
            IHBS_H_IDLE: begin
                cmdReady_d = 1'b1;
                if (cmdValid && cmdReady_q) begin
                    cmdReady_d = 1'b0;
                    kind_d = cmdKind;
                    wide_d = cmdWide;
                    sa_d = cmdAddr;
                    aen_d = cmdDma;
                    bale_d = 1'b1;
                    sdOut_d = cmdData;
                    cnt_d = 8'(`IHBS_T_ADDR_CYC);
                    st_d = IHBS_H_ADDR;
                end
            end
            IHBS_H_ADDR: begin
                cnt_d = cnt_q - 8'h01;
                if (cnt_q == 8'h01) begin
                    bale_d = 1'b0;
                    stb_d = stbFor(kind_q, sa_q, wide_q);
                    sdOe_d = (kind_q == IHBS_IO_WR) ||
                             (kind_q == IHBS_MEM_WR);
                    cnt_d = 8'(`IHBS_T_STB_CYC);
                    st_d = IHBS_H_STB;
                end
            end
            IHBS_H_STB: begin
                if (cnt_q != 8'h00) begin
                    cnt_d = cnt_q - 8'h01;
                // hold strobe while ready is low
                end else if (pinS2_q[0]) begin
                    stb_d = `IHBS_STB_IDLE;
                    sdOe_d = 1'b0;
                    aen_d = 1'b0;
                    rspValid_d = 1'b1;
                    rspData_d = sdS2_q;
                    rspIo16_d = !pinS2_q[1];
                    cnt_d = 8'(`IHBS_T_REC_CYC);
                    st_d = IHBS_H_REC;
                end
            end
            IHBS_H_REC: begin
                cnt_d = cnt_q - 8'h01;
                if (cnt_q == 8'h01) begin
                    cmdReady_d = 1'b1;
                    st_d = IHBS_H_IDLE;
                end
            end
        endcase
    end

    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            st_q <= IHBS_H_IDLE;
            cnt_q <= 8'h00;
            kind_q <= IHBS_IO_RD;
            wide_q <= 1'b0;
            sa_q <= 24'h000000;
            aen_q <= 1'b0;
            bale_q <= 1'b0;
            stb_q <= `IHBS_STB_IDLE;
            sdOut_q <= 16'h0000;
            sdOe_q <= 1'b0;
            cmdReady_q <= 1'b0;
            rspValid_q <= 1'b0;
            rspData_q <= 16'h0000;
            rspIo16_q <= 1'b0;
        end else begin
            st_q <= st_d;
            cnt_q <= cnt_d;
            kind_q <= kind_d;
            wide_q <= wide_d;
            sa_q <= sa_d;
            aen_q <= aen_d;
            bale_q <= bale_d;
            stb_q <= stb_d;
            sdOut_q <= sdOut_d;
            sdOe_q <= sdOe_d;
            cmdReady_q <= cmdReady_d;
            rspValid_q <= rspValid_d;
            rspData_q <= rspData_d;
            rspIo16_q <= rspIo16_d;
        end
    end

    assign bus.sa = sa_q;
    assign bus.aen = aen_q;
    assign bus.bale = bale_q;
    assign bus.stb = stb_q;
    assign bus.hostSd = sdOut_q;
    assign bus.hostSdOe = sdOe_q;
    assign cmdReady = cmdReady_q;
    assign rspValid = rspValid_q;
    assign rspData = rspData_q;
    assign rspIo16 = rspIo16_q;
    assign irqLevel = pinS2_q[6:2];
endmodule : ihbs_host

// [hdl/ihbs_pkg.sv]
// Types shared by both ends of the ISA host bus slave front end.
// Assumes the constants header is compiled alongside.
package ihbs_pkg;
    typedef logic [23:0] ihbs_addr_t;
    typedef logic [15:0] ihbs_data_t;
    // Active-low strobe set driven by the host
    typedef struct packed {
        logic smemrN;
        logic smemwN;
        logic memrN;
        logic memwN;
        logic iorN;
        logic iowN;
        logic sbheN;
    } ihbs_stb_t;
    typedef enum logic [1:0] {
        IHBS_IO_RD,
        IHBS_IO_WR,
        IHBS_MEM_RD,
        IHBS_MEM_WR
    } ihbs_kind_t;
    typedef enum {IHBS_D_IDLE, IHBS_D_WAIT, IHBS_D_HOLD} ihbs_dst_t;
    typedef enum {IHBS_H_IDLE, IHBS_H_ADDR, IHBS_H_STB, IHBS_H_REC} ihbs_hst_t;
endpackage : ihbs_pkg

// [tb/ihbs_bus_asserts.sv]
// Checker on the carrier joining the host and device ends.
// Assumes one clock; carrier wires arrive as plain inputs.
`timescale 1ns/1ps
module ihbs_bus_asserts (
    input wire logic clock, // Clock
    input wire logic rstn, // Reset, active low
    input wire ihbs_pkg::ihbs_addr_t sa, // Address
    input wire logic aen, // DMA flag
    input wire ihbs_pkg::ihbs_stb_t stb, // Strobes
    input wire logic [1:0] devSdOe, // Lane enables
    input wire logic cs16Oe, // IO16 pull
    input wire logic rdyOe, // Ready pull
    input wire logic [4:0] irqOe // Irq enables
);
    import ihbs_pkg::*;
    logic idle;
    assign idle = stb.smemrN & stb.smemwN & stb.memrN & stb.memwN
                  & stb.iorN & stb.iowN;
    default clocking cb @(posedge clock);
    endclocking
    default disable iff (!rstn);
    // ------------------------------------------------------------
    // Properties
    // ------------------------------------------------------------
    property p_rdy_in_cycle; rdyOe |-> !idle; endproperty
    a_rdy_in_cycle: assert property (p_rdy_in_cycle)
        else $error("ready pulled outside a cycle");
    property p_hold_wait; rdyOe && !idle |=> !idle; endproperty
    a_hold_wait: assert property (p_hold_wait)
        else $error("strobe released while ready low");
    property p_rdy_lat; $rose(rdyOe) |-> $past(idle, 5) && !$past(idle, 4);
    endproperty
    a_rdy_lat: assert property (p_rdy_lat)
        else $error("ready pull not four cycles after strobe");
    property p_dma_io; aen && !(stb.iorN && stb.iowN) |-> !rdyOe; endproperty
    a_dma_io: assert property (p_dma_io)
        else $error("IO answered during DMA");
    property p_short_mb; sa[23:20] != 4'h0 |-> stb.smemrN && stb.smemwN;
    endproperty
    a_short_mb: assert property (p_short_mb)
        else $error("short strobe above first megabyte");
    property p_rd_drive; $rose(|devSdOe) |-> !(stb.iorN && stb.memrN);
    endproperty
    a_rd_drive: assert property (p_rd_drive)
        else $error("data driven without read strobe");
    property p_upper; $rose(devSdOe[1]) |-> !stb.sbheN; endproperty
    a_upper: assert property (p_upper)
        else $error("upper lane without high enable");
    property p_addr; !idle |-> $stable(sa); endproperty
    a_addr: assert property (p_addr)
        else $error("address moved during strobe");
    property p_irq; $onehot0(irqOe); endproperty
    a_irq: assert property (p_irq)
        else $error("more than one interrupt driven");
    c_io16: cover property ($rose(cs16Oe));
    c_wide: cover property ($rose(devSdOe[1]));
    c_dma: cover property (aen && !stb.iorN);
endmodule : ihbs_bus_asserts

// [tb/tb_top.sv]
// Bench for the host and device ends joined back to back.
// Assumes carrier, both ends and checker are compiled first.
`timescale 1ns/1ps
module tb_top;
    import ihbs_pkg::*;
    typedef struct packed {logic rd; logic io16; ihbs_data_t d;} ihbs_rsp_t;
    typedef struct packed {
        logic wr; logic mem; logic wide; ihbs_addr_t a; ihbs_data_t d;
    } ihbs_req_t;
    logic clock = 1'b0, rstn = 1'b0, cmdValid = 1'b0, cmdDma = 1'b0;
    logic cmdWide = 1'b0, cfgLoad = 1'b0, intReq = 1'b0, ackValid = 1'b0;
    ihbs_kind_t cmdKind = IHBS_IO_RD;
    ihbs_addr_t cmdAddr = 24'h000000, reqAddr;
    ihbs_data_t cmdData = 16'h0000, ackData = 16'h0000, rspData, reqWdata;
    logic cmdReady, rspValid, rspIo16, reqValid, reqWrite, reqMem;
    logic reqWide, sys16;
    logic [4:0] irqLevel;
    logic [11:0] ioBase = 12'h2A3;
    logic [9:0] memBase = 10'h3C5;
    logic [2:0] cfgIrqSel = 3'h7;
    logic [31:0] seed = 32'hF438102B;
    int error_cnt = 0, num_checks = 0;
    ihbs_rsp_t qRsp[$], eRsp;
    ihbs_req_t qReq[$], eReq;
    ihbs_bus_if u_ihbs_bus_if ();
    ihbs_host u_ihbs_host (.clock(clock), .rstn(rstn),
        .bus(u_ihbs_bus_if.host), .cmdValid(cmdValid), .cmdKind(cmdKind),
        .cmdDma(cmdDma), .cmdWide(cmdWide), .cmdAddr(cmdAddr),
        .cmdData(cmdData), .cmdReady(cmdReady), .rspValid(rspValid),
        .rspData(rspData), .rspIo16(rspIo16), .irqLevel(irqLevel));
    ihbs_dev u_ihbs_dev (.clock(clock), .rstn(rstn),
        .bus(u_ihbs_bus_if.dev), .ioBase(ioBase), .memBase(memBase),
        .cfgIrqSel(cfgIrqSel), .cfgLoad(cfgLoad), .intReq(intReq),
        .reqValid(reqValid), .reqWrite(reqWrite), .reqMem(reqMem),
        .reqWide(reqWide), .reqAddr(reqAddr), .reqWdata(reqWdata),
        .ackValid(ackValid), .ackData(ackData), .sys16(sys16));
    ihbs_bus_asserts u_ihbs_bus_asserts (.clock(clock), .rstn(rstn),
        .sa(u_ihbs_bus_if.sa), .aen(u_ihbs_bus_if.aen),
        .stb(u_ihbs_bus_if.stb), .devSdOe(u_ihbs_bus_if.devSdOe),
        .cs16Oe(u_ihbs_bus_if.cs16Oe), .rdyOe(u_ihbs_bus_if.rdyOe),
        .irqOe(u_ihbs_bus_if.irqOe));
    initial begin
        forever #2 clock = ~clock;
    end
    function automatic logic [31:0] xs(input logic [31:0] s);
        s = s ^ (s << 13);
        s = s ^ (s >> 17);
        return s ^ (s << 5);
    endfunction : xs
    task automatic check(input logic [23:0] got, input logic [23:0] exp);
        num_checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("[ERR] %0t seen %h wanted %h", $time, got, exp);
        end
    endtask : check
    task automatic report_and_stop;
        $display("checks %0d mismatches %0d", num_checks, error_cnt);
        if (error_cnt == 0 && num_checks > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask : report_and_stop
    task automatic run(input ihbs_kind_t k, input logic dma, wide,
                       input ihbs_addr_t a, input logic hit);
        ihbs_rsp_t e;
        logic io;
        seed = xs(seed);
        io = k inside {IHBS_IO_RD, IHBS_IO_WR};
        e.rd = k inside {IHBS_IO_RD, IHBS_MEM_RD};
        e.io16 = hit && io;
        e.d = !hit ? 16'hFFFF : wide ? seed[15:0] : {8'hFF, seed[7:0]};
        qRsp.push_back(e);
        if (hit) begin
            qReq.push_back({!e.rd, !io, wide, a, seed[15:0]});
        end
        cmdKind = k;
        {cmdDma, cmdWide, cmdAddr} = {dma, wide, a};
        {cmdData, ackData} = {seed[15:0], seed[15:0]};
        for (int n = 0; cmdReady !== 1'b1 || n == 0; n++) begin
            if (n == 60) error_cnt++;
            if (n == 60) report_and_stop();
            @(negedge clock);
        end
        cmdValid = 1'b1;
        @(negedge clock);
        cmdValid = 1'b0;
        for (int n = 0; qRsp.size() != 0; n++) begin
            if (n == 200) error_cnt++;
            if (n == 200) report_and_stop();
            @(negedge clock);
        end
    endtask : run
    always @(posedge clock) begin
        if (rspValid === 1'b1) begin
            eRsp = qRsp.pop_front();
            check(rspIo16, eRsp.io16);
            if (eRsp.rd) check(rspData, eRsp.d);
        end
    end
    initial begin : responder
        forever begin
            @(posedge clock);
            if (reqValid === 1'b1) begin
                check(qReq.size() != 0, 1'b1);
                eReq = qReq.pop_front();
                check({reqWrite, reqMem, reqWide},
                      {eReq.wr, eReq.mem, eReq.wide});
                check(reqAddr, eReq.a);
                if (eReq.wr) check(reqWdata, eReq.d);
                repeat (seed[2:0]) @(posedge clock);
                @(negedge clock);
                ackValid = 1'b1;
                @(negedge clock);
                ackValid = 1'b0;
            end
        end
    end
    initial begin : main
        repeat (10) @(negedge clock);
        rstn = 1'b1;
        intReq = 1'b1;
        repeat (6) @(negedge clock);
        check(sys16, 1'b1);
        check(irqLevel, 5'h00);
        for (int i = 0; i < 4; i++) begin
            run(ihbs_kind_t'(i % 2), 0, i / 2, {8'h00, ioBase, 4'h6}, 1);
            run(ihbs_kind_t'(i % 2 + 2), 0, i / 2, {memBase, 14'h0A5C}, 1);
        end
        run(IHBS_IO_RD, 0, 1, {8'h00, ioBase ^ 12'h001, 4'h0}, 0);
        run(IHBS_IO_RD, 1, 1, {8'h00, ioBase, 4'h2}, 0);
        run(IHBS_IO_WR, 1, 0, {8'h00, ioBase, 4'h4}, 0);
        $display("test fixed cycles done");
        memBase = 10'h012;
        for (int i = 0; i < 12; i++) begin
            seed = xs(seed);
            run(ihbs_kind_t'(seed[1:0]), 0, seed[2], seed[1] ?
                {memBase, 1'b0, seed[20:8]} : {8'h00, ioBase, seed[7:4]}, 1);
        end
        run(IHBS_MEM_RD, 0, 1, {memBase ^ 10'h001, 14'h0000}, 0);
        $display("test random cycles done");
        for (int s = 0; s < 8; s++) begin
            cfgIrqSel = s[2:0];
            cfgLoad = 1'b1;
            @(negedge clock);
            cfgLoad = 1'b0;
            repeat (6) @(negedge clock);
            check(irqLevel, s < 5 ? 5'h01 << s : 5'h00);
        end
        $display("test interrupts done");
        report_and_stop();
    end
endmodule : tb_top
